//--- logic/slcd_pkg.sv
// Purpose: shared constants and helpers for the servo link command decoder
// Assumes: link characters are ascii hex digits, most significant first
// Notes:   reply characters and field layouts are shared by both ends
`default_nettype none
package slcd_pkg;
  // command codes and data numbers
  localparam logic [7:0]  CMD_STAT_RD  = 8'h01;
  localparam logic [7:0]  CMD_STAT_CLR = 8'h81;
  localparam logic [7:0]  CMD_GROUP    = 8'h9f;
  localparam logic [7:0]  CMD_AUX_WR   = 8'hcb;
  localparam logic [7:0]  DNO_ZERO     = 8'h00;
  localparam logic [7:0]  DNO_FB_PULSE = 8'h80;
  localparam logic [15:0] CLR_KEY      = 16'h1ea5;
  // frame lengths in characters
  localparam logic [3:0]  HDR_CHARS    = 4'h4;
  localparam logic [3:0]  AUX_CHARS    = 4'h8;
  localparam logic [3:0]  SHORT_CHARS  = 4'h4;
  localparam logic [3:0]  STAT_CHARS   = 4'hc;
  localparam logic [3:0]  ACK_CHARS    = 4'h1;
  // one-character answers to writes
  localparam logic [7:0]  ACK_OK       = 8'h41;
  localparam logic [7:0]  ACK_ERR      = 8'h45;
  // data processing information
  localparam logic [3:0]  TYPE_DEC     = 4'h0;
  localparam logic [3:0]  TYPE_HEX     = 4'h1;
  localparam logic [3:0]  POINT_NONE   = 4'h0;
  // reset values and conversion sizes
  localparam logic [31:0] AUX_RESET    = 32'h0;
  localparam logic [15:0] GROUP_RESET  = 16'h0;
  localparam logic [31:0] FB_RESET     = 32'h0;
  localparam int          BCD_DIGITS   = 10;
  localparam logic [5:0]  BIN_LAST     = 6'h1f;

  // ascii hex digit to {valid, nibble}
  function automatic logic [4:0] char_to_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c[3:0] + 4'h9)};
    else return 5'h00;
  endfunction : char_to_nib

  // nibble to upper-case ascii hex digit
  function automatic logic [7:0] nib_to_char(input logic [3:0] n);
    if (n <= 4'h9) return {4'h3, n};
    else return {4'h4, 4'(n - 4'h9)};
  endfunction : nib_to_char

  // number of data characters that follow the data number
  function automatic logic [3:0] data_chars(input logic [7:0] cmd);
    case (cmd)
      CMD_AUX_WR:              return AUX_CHARS;
      CMD_GROUP, CMD_STAT_CLR: return SHORT_CHARS;
      default:                 return 4'h0;
    endcase
  endfunction : data_chars
endpackage : slcd_pkg
`default_nettype wire

//--- logic/slcd_link_if.sv
// Purpose: character link between master station and servo slave
// Assumes: both ends on one clock, valid/ready per character
// Notes:   m2s carries commands, s2m carries replies
`timescale 1ns/1ps
`default_nettype none
interface slcd_link_if;
  logic [7:0] m2s_char;
  logic       m2s_valid;
  logic       m2s_ready;
  logic [7:0] s2m_char;
  logic       s2m_valid;
  logic       s2m_ready;

  // slave end
  modport dev  (input  m2s_char, m2s_valid, s2m_ready,
                output m2s_ready, s2m_char, s2m_valid);
  // master end
  modport host (output m2s_char, m2s_valid, s2m_ready,
                input  m2s_ready, s2m_char, s2m_valid);
endinterface : slcd_link_if
`default_nettype wire

//--- logic/slcd_dev.sv
// Purpose: slave-side command interpreter of the servo link
// Assumes: master waits for each reply before the next command
// Notes:   one frame at a time, no buffering beyond the frame
// Functional notes
// R1: CB with 01..0F writes aux table 1..15
// R2: 9F 00 with four chars sets group
// R3: every command frame gets a fitting reply
// R4: master converts type 0 hex to decimal
// R5: master uses type 1 value as hex
// R6: point n sits n digits up, 0 none
// R7: decimal write without point is refused
// R8: master sends point zero for hex writes
// R9: master sends integer as hex with point
// R10: master reads status with 01 and item
// R11: status reply carries value, type and point
// R12: 81 00 1EA5 clears fed-back pulse count
// R13: master clears directly after the status read
// R14: fields are hex chars, msb first
`timescale 1ns/1ps
`default_nettype none
module slcd_dev (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // serial link, slave end
  slcd_link_if.dev         link,
  // auxiliary-function table
  output logic             aux_wr,
  output logic [3:0]       aux_wr_idx,
  input  wire logic [3:0]  aux_rd_idx,
  output logic [31:0]      aux_rd_word,
  // group setting
  output logic [15:0]      group_word,
  // status display items
  input  wire logic        fb_pulse,
  output logic [7:0]       stat_sel,
  input  wire logic [31:0] stat_value,
  input  wire logic [3:0]  stat_point,
  input  wire logic [3:0]  stat_type,
  // refused frame
  output logic             cmd_err
);
  import slcd_pkg::*;

  typedef enum logic [2:0] {
    ST_RX   = 3'b001,
    ST_EXEC = 3'b010,
    ST_TX   = 3'b100
  } slcd_dev_st_type;

  slcd_dev_st_type state_q, state_d;
  logic [47:0] rx_q, rx_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        bad_q, bad_d;
  logic [7:0]  cmd_q, cmd_d;
  logic [95:0] tx_q, tx_d;
  logic [3:0]  left_q, left_d;
  logic [7:0]  sel_q, sel_d;
  logic        armed_q, armed_d;
  logic [15:0] group_q, group_d;
  logic [31:0] aux_q [1:15];
  logic [31:0] aux_d [1:15];
  logic [31:0] rd_q, rd_d;
  logic        wr_q, wr_d;
  logic [3:0]  widx_q, widx_d;
  logic        err_q, err_d;
  logic [31:0] fb_q, fb_d;
  logic [4:0]  nib;
  logic [3:0]  dc;
  logic [7:0]  dno;
  logic [3:0]  typ;
  logic [3:0]  pnt;
  logic [31:0] sval;
  logic [3:0]  spnt;
  logic [3:0]  styp;
  logic        ok;

  // frame fields; data number sits just above the data characters
  assign nib  = char_to_nib(link.m2s_char); // R14
  assign dc   = data_chars(cmd_q);
  assign dno  = rx_q[{dc, 2'b00} +: 8]; // R14
  assign typ  = rx_q[31:28];
  assign pnt  = rx_q[27:24];
  // cumulative pulse item is held here, all others come from outside
  assign sval = (sel_q == DNO_FB_PULSE) ? fb_q : stat_value;
  assign spnt = (sel_q == DNO_FB_PULSE) ? POINT_NONE : stat_point;
  assign styp = (sel_q == DNO_FB_PULSE) ? TYPE_DEC : stat_type;

  // link handshakes follow the state
  assign link.m2s_ready = (state_q == ST_RX);
  assign link.s2m_valid = (state_q == ST_TX);
  assign link.s2m_char  = tx_q[95:88];

  // user side outputs, all from flops
  assign aux_wr      = wr_q;
  assign aux_wr_idx  = widx_q;
  assign aux_rd_word = rd_q;
  assign group_word  = group_q;
  assign stat_sel    = sel_q;
  assign cmd_err     = err_q;

  // next-state logic for frame intake, execution and reply
  always_comb begin
    state_d = state_q;
    rx_d    = rx_q;
    cnt_d   = cnt_q;
    bad_d   = bad_q;
    cmd_d   = cmd_q;
    tx_d    = tx_q;
    left_d  = left_q;
    sel_d   = sel_q;
    armed_d = armed_q;
    group_d = group_q;
    aux_d   = aux_q;
    wr_d    = 1'b0;
    widx_d  = widx_q;
    err_d   = 1'b0;
    ok      = 1'b0;
    // pulse counting; a pulse in the clear cycle survives
    fb_d    = fb_q + 32'(fb_pulse);
    rd_d    = (aux_rd_idx == 4'h0) ? AUX_RESET : aux_q[aux_rd_idx];
    case (state_q)
      ST_RX: begin
        if (link.m2s_valid) begin
          rx_d  = {rx_q[43:0], nib[3:0]}; // R14
          cnt_d = cnt_q + 4'h1;
          bad_d = bad_q | ~nib[4];
          if (cnt_q == 4'h1) begin
            cmd_d = {rx_q[3:0], nib[3:0]};
          end
          // frame length is known once the command is in
          if (cnt_d == HDR_CHARS + data_chars(cmd_d)) begin
            state_d = ST_EXEC;
            if (cmd_d == CMD_STAT_RD) begin
              sel_d = rx_d[7:0]; // R11
            end
          end
        end
      end
      ST_EXEC: begin
        tx_d    = {ACK_ERR, 88'h0};
        left_d  = ACK_CHARS;
        // only a clear that directly follows a read may act
        armed_d = 1'b0;
        if (!bad_q) begin
          case (cmd_q)
            CMD_AUX_WR: begin
              // decimal data must carry a point position
              if (dno[7:4] == 4'h0 && dno[3:0] != 4'h0 &&
                  typ <= TYPE_HEX &&
                  !(typ == TYPE_DEC && pnt == POINT_NONE)) begin // R7
                aux_d[dno[3:0]] = rx_q[31:0]; // R1
                wr_d   = 1'b1; // R1
                widx_d = dno[3:0];
                ok     = 1'b1;
              end
            end
            CMD_GROUP: begin
              if (dno == DNO_ZERO) begin
                group_d = rx_q[15:0]; // R2
                ok      = 1'b1;
              end
            end
            CMD_STAT_CLR: begin
              if (dno == DNO_ZERO && rx_q[15:0] == CLR_KEY &&
                  armed_q && sel_q == DNO_FB_PULSE) begin
                fb_d = 32'(fb_pulse); // R12
                ok   = 1'b1;
              end
            end
            CMD_STAT_RD: begin
              // twelve chars: 0, 0, point, type, eight value digits
              tx_d[95:88] = nib_to_char(4'h0);
              tx_d[87:80] = nib_to_char(4'h0);
              tx_d[79:72] = nib_to_char(spnt); // R6
              tx_d[71:64] = nib_to_char(styp); // R11
              for (int i = 0; i < 8; i++) begin
                tx_d[8*i +: 8] = nib_to_char(sval[4*i +: 4]); // R14
              end
              left_d  = STAT_CHARS; // R11
              armed_d = 1'b1;
            end
            default: ok = 1'b0;
          endcase
        end
        // writes answer with one character
        if (ok) begin
          tx_d = {ACK_OK, 88'h0}; // R3
        end
        err_d   = ~ok & (bad_q | cmd_q != CMD_STAT_RD);
        state_d = ST_TX; // R3
      end
      ST_TX: begin
        if (link.s2m_ready) begin
          tx_d   = {tx_q[87:0], 8'h00};
          left_d = left_q - 4'h1;
          if (left_q == 4'h1) begin
            state_d = ST_RX;
            cnt_d   = 4'h0;
            bad_d   = 1'b0;
          end
        end
      end
      default: state_d = ST_RX;
    endcase
  end

  // registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_RX;
      rx_q    <= 48'h0;
      cnt_q   <= 4'h0;
      bad_q   <= 1'b0;
      cmd_q   <= 8'h00;
      tx_q    <= 96'h0;
      left_q  <= 4'h0;
      sel_q   <= 8'h00;
      armed_q <= 1'b0;
      group_q <= GROUP_RESET;
      rd_q    <= AUX_RESET;
      wr_q    <= 1'b0;
      widx_q  <= 4'h0;
      err_q   <= 1'b0;
      fb_q    <= FB_RESET;
      for (int i = 1; i <= 15; i++) begin
        aux_q[i] <= AUX_RESET;
      end
    end else begin
      state_q <= state_d;
      rx_q    <= rx_d;
      cnt_q   <= cnt_d;
      bad_q   <= bad_d;
      cmd_q   <= cmd_d;
      tx_q    <= tx_d;
      left_q  <= left_d;
      sel_q   <= sel_d;
      armed_q <= armed_d;
      group_q <= group_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      widx_q  <= widx_d;
      err_q   <= err_d;
      fb_q    <= fb_d;
      aux_q   <= aux_d;
    end
  end
endmodule : slcd_dev
`default_nettype wire

//--- logic/slcd_host.sv
// Purpose: master-station end of the servo link
// Assumes: one outstanding command, reply length known from command
// Notes:   decimal replies are converted to bcd, 32 cycles
`timescale 1ns/1ps
`default_nettype none
module slcd_host (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // serial link, master end
  slcd_link_if.host        link,
  // command request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [7:0]  req_dno,
  input  wire logic        req_hex,
  input  wire logic [3:0]  req_point,
  input  wire logic [23:0] req_value,
  // answer
  output logic             rsp_valid,
  output logic             rsp_ok,
  output logic [31:0]      rsp_value,
  output logic [3:0]       rsp_point,
  output logic [3:0]       rsp_type,
  output logic [39:0]      rsp_bcd
);
  import slcd_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_TX   = 4'b0010,
    H_RX   = 4'b0100,
    H_CONV = 4'b1000
  } slcd_host_st_type;

  slcd_host_st_type st_q, st_d;
  logic [43:0] sr_q, sr_d;
  logic [7:0]  ch_q, ch_d;
  logic [3:0]  left_q, left_d;
  logic [3:0]  exp_q, exp_d;
  logic [3:0]  rcnt_q, rcnt_d;
  logic [47:0] rx_q, rx_d;
  logic [31:0] bin_q, bin_d;
  logic [39:0] bcd_q, bcd_d;
  logic [5:0]  it_q, it_d;
  logic        vld_q, vld_d;
  logic        ok_q, ok_d;
  logic        rdok_q, rdok_d;
  logic [31:0] val_q, val_d;
  logic [3:0]  pnt_q, pnt_d;
  logic [3:0]  typ_q, typ_d;
  logic [47:0] frame;
  logic [39:0] adj;
  logic [4:0]  rnib;

  // reply char decoded once; a select on a call result is not portable
  assign rnib = char_to_nib(link.s2m_char); // R14

  // request frame, hex digits msb first
  always_comb begin
    if (req_cmd == CMD_AUX_WR) begin
      frame = {req_cmd, req_dno, req_hex ? TYPE_HEX : TYPE_DEC,
               req_hex ? POINT_NONE : req_point, req_value}; // R8 R9
    end else if (data_chars(req_cmd) == SHORT_CHARS) begin
      frame = {req_cmd, req_dno, req_value[15:0], 16'h0}; // R2 R12
    end else begin
      frame = {req_cmd, req_dno, 32'h0}; // R10
    end
  end

  // double dabble: add three to each digit of five or more
  for (genvar g = 0; g < BCD_DIGITS; g++) begin : g_adj
    assign adj[4*g +: 4] = (bcd_q[4*g +: 4] >= 4'h5) ?
                           4'(bcd_q[4*g +: 4] + 4'h3) : bcd_q[4*g +: 4];
  end

  assign req_ready      = (st_q == H_IDLE);
  assign link.m2s_valid = (st_q == H_TX);
  assign link.m2s_char  = ch_q;
  assign link.s2m_ready = (st_q == H_RX);
  assign rsp_valid      = vld_q;
  assign rsp_ok         = ok_q;
  assign rsp_value      = val_q;
  assign rsp_point      = pnt_q;
  assign rsp_type       = typ_q;
  assign rsp_bcd        = bcd_q;

  // next-state logic
  always_comb begin
    st_d   = st_q;
    sr_d   = sr_q;
    ch_d   = ch_q;
    left_d = left_q;
    exp_d  = exp_q;
    rcnt_d = rcnt_q;
    rx_d   = rx_q;
    bin_d  = bin_q;
    bcd_d  = bcd_q;
    it_d   = it_q;
    vld_d  = 1'b0;
    ok_d   = ok_q;
    rdok_d = rdok_q;
    val_d  = val_q;
    pnt_d  = pnt_q;
    typ_d  = typ_q;
    case (st_q)
      H_IDLE: begin
        if (req_valid) begin
          rdok_d = 1'b0;
          // a clear not right after a read is refused locally
          if (req_cmd == CMD_STAT_CLR && !rdok_q) begin // R13
            vld_d = 1'b1;
            ok_d  = 1'b0;
          end else begin
            ch_d   = nib_to_char(frame[47:44]); // R14
            sr_d   = frame[43:0];
            left_d = HDR_CHARS + data_chars(req_cmd);
            exp_d  = (req_cmd == CMD_STAT_RD) ? STAT_CHARS : ACK_CHARS;
            rcnt_d = 4'h0;
            st_d   = H_TX;
          end
        end
      end
      H_TX: begin
        if (link.m2s_ready) begin
          ch_d   = nib_to_char(sr_q[43:40]);
          sr_d   = {sr_q[39:0], 4'h0};
          left_d = left_q - 4'h1;
          if (left_q == 4'h1) begin
            st_d = H_RX;
          end
        end
      end
      H_RX: begin
        if (link.s2m_valid) begin
          rx_d   = {rx_q[43:0], rnib[3:0]};
          rcnt_d = rcnt_q + 4'h1;
          if (exp_q == ACK_CHARS) begin
            ok_d  = (link.s2m_char == ACK_OK);
            vld_d = 1'b1;
            st_d  = H_IDLE;
          end else if (rcnt_d == STAT_CHARS) begin
            val_d  = rx_d[31:0];
            pnt_d  = rx_d[39:36]; // R6
            typ_d  = rx_d[35:32];
            ok_d   = 1'b1;
            rdok_d = 1'b1;
            bcd_d  = 40'h0;
            if (rx_d[35:32] == TYPE_DEC) begin
              bin_d = rx_d[31:0]; // R4
              it_d  = 6'h0;
              st_d  = H_CONV;
            end else begin
              vld_d = 1'b1; // R5
              st_d  = H_IDLE;
            end
          end
        end
      end
      H_CONV: begin
        {bcd_d, bin_d} = {adj[38:0], bin_q, 1'b0}; // R4
        it_d = it_q + 6'h1;
        if (it_q == BIN_LAST) begin
          vld_d = 1'b1;
          st_d  = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q   <= H_IDLE;
      sr_q   <= 44'h0;
      ch_q   <= 8'h00;
      left_q <= 4'h0;
      exp_q  <= 4'h0;
      rcnt_q <= 4'h0;
      rx_q   <= 48'h0;
      bin_q  <= 32'h0;
      bcd_q  <= 40'h0;
      it_q   <= 6'h0;
      vld_q  <= 1'b0;
      ok_q   <= 1'b0;
      rdok_q <= 1'b0;
      val_q  <= 32'h0;
      pnt_q  <= 4'h0;
      typ_q  <= 4'h0;
    end else begin
      st_q   <= st_d;
      sr_q   <= sr_d;
      ch_q   <= ch_d;
      left_q <= left_d;
      exp_q  <= exp_d;
      rcnt_q <= rcnt_d;
      rx_q   <= rx_d;
      bin_q  <= bin_d;
      bcd_q  <= bcd_d;
      it_q   <= it_d;
      vld_q  <= vld_d;
      ok_q   <= ok_d;
      rdok_q <= rdok_d;
      val_q  <= val_d;
      pnt_q  <= pnt_d;
      typ_q  <= typ_d;
    end
  end
endmodule : slcd_host
`default_nettype wire

//--- verification/slcd_link_chk.sv
// Purpose: protocol checks on the character link between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes:   frame length is tracked from the first two command chars
`timescale 1ns/1ps
`default_nettype none
module slcd_link_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // master to slave
  input wire logic [7:0] m2s_char,
  input wire logic       m2s_valid,
  input wire logic       m2s_ready,
  // slave to master
  input wire logic [7:0] s2m_char,
  input wire logic       s2m_valid,
  input wire logic       s2m_ready
);
  logic [3:0] n_q, n_d, flen;
  logic [7:0] c0_q, c0_d, c1_q, c1_d, c4_q, c4_d;
  logic       hs, fin;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  assign hs = m2s_valid && m2s_ready;

  // frame tracking; unknown commands carry no data chars
  always_comb begin
    flen = 4'h4;
    if ({c0_q, c1_q} == 16'h4342) flen = 4'hc;
    else if ({c0_q, c1_q} == 16'h3946 || {c0_q, c1_q} == 16'h3831)
      flen = 4'h8;
    fin  = hs && (n_q == flen - 4'h1);
    n_d  = n_q;
    c0_d = c0_q;
    c1_d = c1_q;
    c4_d = c4_q;
    if (hs) begin
      n_d = fin ? 4'h0 : n_q + 4'h1;
      if (n_q == 4'h0) c0_d = m2s_char;
      if (n_q == 4'h1) c1_d = m2s_char;
      if (n_q == 4'h4) c4_d = m2s_char;
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      n_q  <= 4'h0;
      c0_q <= 8'h00;
      c1_q <= 8'h00;
      c4_q <= 8'h00;
    end else begin
      n_q  <= n_d;
      c0_q <= c0_d;
      c1_q <= c1_d;
      c4_q <= c4_d;
    end
  end

  m2s_hold_a: assert property
    (m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_char))
    else $error("command char changed before it was taken");
  s2m_hold_a: assert property
    (s2m_valid && !s2m_ready |=> s2m_valid && $stable(s2m_char))
    else $error("reply char changed before it was taken");
  m2s_hex_a: assert property
    (m2s_valid |-> m2s_char inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("command char is not an upper-case hex digit");
  s2m_hex_a: assert property
    (s2m_valid |-> s2m_char inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("reply char is not an upper-case hex digit");
  reply_time_a: assert property
    (fin |=> !s2m_valid ##1 s2m_valid)
    else $error("reply did not start two cycles after the frame");
  ready_drop_a: assert property
    (fin |=> !m2s_ready [*2])
    else $error("slave kept taking chars after a frame ended");
  reply_busy_a: assert property
    (s2m_valid |-> !m2s_ready && !m2s_valid)
    else $error("command traffic while a reply is pending");
  write_ack_a: assert property
    (fin && flen != 4'h4 |=> ##1 s2m_char inside {8'h41, 8'h45})
    else $error("write frame not answered with a single ack char");
  stat_lead_a: assert property
    (fin && {c0_q, c1_q} == 16'h3031 |=> ##1 s2m_char == 8'h30)
    else $error("status reply does not open with a zero char");
  hex_point_a: assert property
    (hs && n_q == 4'h5 && flen == 4'hc && c4_q == 8'h31 |->
     m2s_char == 8'h30)
    else $error("hex write sent with a nonzero point");
endmodule : slcd_link_chk
`default_nettype wire

//--- verification/servo_link_command_decoder_test.sv
// Purpose: self-checking bench joining host and slave ends of the link
// Assumes: inputs change on the falling edge, outputs read there too
// Notes:   random values come from a fixed seed, corners are hand-made
`timescale 1ns/1ps
`default_nettype none
module servo_link_command_decoder_test;
  import slcd_pkg::*;
  logic        clk, sys_rst, req_valid, req_ready, req_hex, rsp_valid;
  logic        rsp_ok, aux_wr, fb_pulse, cmd_err, hx;
  logic [7:0]  req_cmd, req_dno, stat_sel, item;
  logic [3:0]  req_point, rsp_point, rsp_type, aux_wr_idx, aux_rd_idx;
  logic [3:0]  stat_point, stat_type, pt;
  logic [23:0] req_value, v;
  logic [31:0] rsp_value, aux_rd_word, stat_value, seed, sv;
  logic [31:0] exp_aux [16];
  logic [15:0] group_word, g;
  logic [39:0] rsp_bcd;
  int          num_errors, n_tests, cycles, n, n_wr, n_ref;

  slcd_link_if link ();
  slcd_host u_slcd_host (.clk(clk), .sys_rst(sys_rst), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_dno(req_dno), .req_hex(req_hex), .req_point(req_point),
    .req_value(req_value), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_value(rsp_value), .rsp_point(rsp_point), .rsp_type(rsp_type),
    .rsp_bcd(rsp_bcd));
  slcd_dev u_slcd_dev (.clk(clk), .sys_rst(sys_rst), .link(link),
    .aux_wr(aux_wr), .aux_wr_idx(aux_wr_idx), .aux_rd_idx(aux_rd_idx),
    .aux_rd_word(aux_rd_word), .group_word(group_word),
    .fb_pulse(fb_pulse), .stat_sel(stat_sel), .stat_value(stat_value),
    .stat_point(stat_point), .stat_type(stat_type), .cmd_err(cmd_err));
  slcd_link_chk u_slcd_link_chk (.clk(clk), .sys_rst(sys_rst),
    .m2s_char(link.m2s_char), .m2s_valid(link.m2s_valid),
    .m2s_ready(link.m2s_ready), .s2m_char(link.s2m_char),
    .s2m_valid(link.s2m_valid), .s2m_ready(link.s2m_ready));

  // clock at 200 MHz
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // one-cycle strobes are counted where they have settled
  always @(negedge clk) begin
    if (aux_wr === 1'b1) n_wr++;
    if (cmd_err === 1'b1) n_ref++;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // expected decimal digits of a binary value
  function automatic logic [39:0] to_bcd(input logic [31:0] x);
    logic [39:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) begin
      r[i*4 +: 4] = 4'(x % 10);
      x = x / 10;
    end
    return r;
  endfunction : to_bcd

  // one request, held until taken, then a bounded wait for the answer
  task automatic send(input logic [7:0] c, input logic [7:0] d,
                      input logic h, input logic [3:0] p,
                      input logic [23:0] x);
    int w;
    // ready is looked at on the falling edge, where it has settled
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    {req_cmd, req_dno, req_hex, req_point, req_value} = {c, d, h, p, x};
    req_valid = 1'b1;
    @(negedge clk) req_valid = 1'b0;
    w = 0;
    while (rsp_valid !== 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    check(40'(rsp_valid), 40'h1);
  endtask : send

  task automatic rd_aux(input int i);
    @(negedge clk) aux_rd_idx = 4'(i);
    @(negedge clk) check(40'(aux_rd_word), 40'(exp_aux[i]));
  endtask : rd_aux

  // status read with given item inputs, all reply fields compared
  task automatic stat(input logic [7:0] d, input logic [31:0] x,
                      input logic [3:0] p, input logic [3:0] t);
    // the pulse item is internal, so its outside inputs must not show
    {stat_value, stat_point, stat_type} =
      (d == DNO_FB_PULSE) ? {~x, 4'h5, 4'h1} : {x, p, t};
    send(CMD_STAT_RD, d, 1'b1, 4'h0, 24'h0);
    check(40'({rsp_ok, stat_sel}), 40'({1'b1, d}));
    check(40'({rsp_value, rsp_point, rsp_type}), 40'({x, p, t}));
    if (t == TYPE_DEC) check(rsp_bcd, to_bcd(x));
  endtask : stat

  initial begin
    seed = 32'h4eab8b90;
    {req_valid, req_hex, fb_pulse, sys_rst} = 4'h1;
    {req_cmd, req_dno, req_point, req_value} = '0;
    {aux_rd_idx, stat_value, stat_point, stat_type} = '0;
    for (int i = 0; i < 16; i++) exp_aux[i] = AUX_RESET;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rd_aux(7);
    // every aux table entry, random hex or decimal
    for (int i = 1; i < 16; i++) begin
      hx = 1'($random(seed));
      pt = 4'h1 + 4'(($random(seed) & 32'hff) % 5);
      v  = 24'($random(seed));
      send(CMD_AUX_WR, 8'(i), hx, pt, v);
      exp_aux[i] = hx ? {8'h10, v} : {4'h0, pt, v};
      check(40'({rsp_ok, aux_wr_idx}), 40'({1'b1, 4'(i)}));
      rd_aux(i);
    end
    // worked example, then a decimal write without a point
    send(CMD_AUX_WR, 8'h03, 1'b0, 4'h2, 24'h00009b);
    exp_aux[3] = 32'h0200009b;
    rd_aux(3);
    send(CMD_AUX_WR, 8'h03, 1'b0, 4'h0, 24'h000005);
    check(40'(rsp_ok), 40'h0);
    rd_aux(3);
    send(CMD_AUX_WR, 8'h00, 1'b1, 4'h0, 24'h1);
    check(40'(rsp_ok), 40'h0);
    send(CMD_AUX_WR, 8'h10, 1'b1, 4'h0, 24'h1);
    check(40'(rsp_ok), 40'h0);
    // group setting, then a bad data number
    g = 16'($random(seed));
    send(CMD_GROUP, DNO_ZERO, 1'b1, 4'h0, {8'h0, g});
    check(40'({rsp_ok, group_word}), 40'({1'b1, g}));
    send(CMD_GROUP, 8'h01, 1'b1, 4'h0, {8'h0, ~g});
    check(40'({rsp_ok, group_word}), 40'({1'b0, g}));
    // a command this end does not know is answered as refused
    send(8'h12, DNO_ZERO, 1'b1, 4'h0, 24'h0);
    check(40'(rsp_ok), 40'h0);
    // status reads of both display types
    stat(8'h05, 32'h00000929, 4'h3, TYPE_DEC);
    for (int k = 0; k < 4; k++) begin
      item = 8'($random(seed)) & 8'h7f;
      sv = $random(seed);
      stat(item, sv, 4'(k + 1), 4'(k % 2));
    end
    // clear after a read of another item, then with no read before it
    send(CMD_STAT_CLR, DNO_ZERO, 1'b1, 4'h0, 24'h001ea5);
    check(40'(rsp_ok), 40'h0);
    send(CMD_STAT_CLR, DNO_ZERO, 1'b1, 4'h0, 24'h001ea5);
    check(40'(rsp_ok), 40'h0);
    // build a pulse count, wrong key keeps it, right key zeroes it
    n = 3 + ($random(seed) & 31);
    @(negedge clk) fb_pulse = 1'b1;
    repeat (n) @(negedge clk);
    fb_pulse = 1'b0;
    stat(DNO_FB_PULSE, 32'(n), POINT_NONE, TYPE_DEC);
    send(CMD_STAT_CLR, DNO_ZERO, 1'b1, 4'h0, 24'h001ea4);
    check(40'(rsp_ok), 40'h0);
    stat(DNO_FB_PULSE, 32'(n), POINT_NONE, TYPE_DEC);
    send(CMD_STAT_CLR, DNO_ZERO, 1'b1, 4'h0, 24'h001ea5);
    check(40'(rsp_ok), 40'h1);
    stat(DNO_FB_PULSE, FB_RESET, POINT_NONE, TYPE_DEC);
    // sixteen accepted table writes, seven frames refused by the slave
    check(40'(n_wr), 40'h10);
    check(40'(n_ref), 40'h7);
    tally_and_finish();
  end
endmodule : servo_link_command_decoder_test
`default_nettype wire
